// *** hdl/pcd_channel.sv ***
`timescale 1ns/1ps
`default_nettype none
module pcd_channel
   import pcd_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   pcd_ch_if.ch ch
);
   // open channel stays in service, only flagged; it sinks nothing anyway
   wire excluded = ch.tied_det | ch.short_det;
   always_ff @(posedge clk) begin
      if (rst) begin
         ch.active <= 1'b0;
         ch.open_flag <= 1'b0;
      end else begin
         // detection runs regardless of enable
         ch.active <= ch.enable & ~excluded;
         ch.open_flag <= ch.open_det;
      end
   end
endmodule
`default_nettype wire

// *** hdl/pcd_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module pcd_top
   import pcd_pkg::*;
#(
   parameter int SHDN_CYC = SHDN_LOW_CYC
)
(
   input wire logic clk,
   input wire logic rst,
   input wire logic dimming_pulse_input,
   input wire logic duty_input,
   input wire logic pump_overvoltage,
   input wire logic [NCH-1:0] open_det,
   input wire logic [NCH-1:0] short_det,
   input wire logic [NCH-1:0] tied_det,
   output logic [CUR_W-1:0] current_code,
   output logic [NCH-1:0] channel_pins_en,
   output logic [NCH-1:0] channel_pins_oe,
   output logic [NCH-1:0] channel_open,
   output logic enabled,
   output logic mode_reeval
);
   // ---------------------------------------------
   // input synchronisers
   // ---------------------------------------------
   logic [1:0] dim_s;
   logic [1:0] duty_s;
   logic [1:0] ov_s;
   logic [NCH-1:0] open_a, open_b, short_a, short_b, tied_a, tied_b;
   always_ff @(posedge clk) begin
      if (rst) begin
         dim_s <= 2'h0;
         duty_s <= 2'h0;
         ov_s <= 2'h0;
         open_a <= '0;
         open_b <= '0;
         short_a <= '0;
         short_b <= '0;
         tied_a <= '0;
         tied_b <= '0;
      end else begin
         dim_s <= {dim_s[0], dimming_pulse_input};
         duty_s <= {duty_s[0], duty_input};
         ov_s <= {ov_s[0], pump_overvoltage};
         open_a <= open_det;
         open_b <= open_a;
         short_a <= short_det;
         short_b <= short_a;
         tied_a <= tied_det;
         tied_b <= tied_a;
      end
   end
   wire dim = dim_s[1];
   wire duty = duty_s[1];
   wire ov = ov_s[1];
   // ---------------------------------------------
   // low interval timer and state
   // ---------------------------------------------
   pcd_state_e state, next_state;
   logic [CNT_W-1:0] low_cnt;
   logic [LVL_W-1:0] level;
   logic [LVL_W-1:0] next_level;
   // saturate at the shutdown count so the counter never wraps
   wire [CNT_W-1:0] cnt_max = CNT_W'(SHDN_CYC);
   wire cnt_sat = (low_cnt >= cnt_max);
   wire glitch = (low_cnt < CNT_W'(MIN_LOW_CYC));
   wire too_long = (low_cnt > CNT_W'(MAX_LOW_CYC));
   wire shdn_hit = (low_cnt >= cnt_max);
   wire step_ok = ~glitch & ~too_long;
   always_comb begin
      next_state = state;
      next_level = level;
      case (state)
         PCD_SHDN: begin
            // dim high enables at full scale
            if (dim) begin
               next_state = PCD_RUN;
               next_level = LVL_RESET;
            end
         end
         PCD_RUN: begin
            if (!dim) begin
               next_state = PCD_LOW;
            end
         end
         PCD_LOW: begin
            if (shdn_hit) begin
               next_state = PCD_SHDN;
               next_level = LVL_RESET;
            end else if (dim) begin
               next_state = PCD_RUN;
               if (step_ok) begin
                  // 5-bit add wraps 31 back to 0
                  next_level = level + LVL_STEP;
               end
            end
         end
         default: begin
            next_state = PCD_SHDN;
            next_level = LVL_RESET;
         end
      endcase
      // overvoltage restarts operation at full scale
      if (ov && state != PCD_SHDN) begin
         next_level = LVL_RESET;
      end
   end
   always_ff @(posedge clk) begin
      if (rst) begin
         state <= PCD_SHDN;
         level <= LVL_RESET;
         low_cnt <= '0;
      end else begin
         state <= next_state;
         level <= next_level;
         if (dim || state == PCD_SHDN) begin
            low_cnt <= '0;
         end else if (!cnt_sat) begin
            low_cnt <= low_cnt + CNT_W'(1);
         end
      end
   end
   // ---------------------------------------------
   // channels
   // ---------------------------------------------
   wire run = (state != PCD_SHDN);
   // a low spell still counts as running until shutdown is reached
   wire drive = run & duty & ~ov;
   logic [NCH-1:0] ch_act;
   logic [NCH-1:0] ch_open;
   genvar g;
   generate
      for (g = 0; g < NCH; g++) begin : g_ch
         pcd_ch_if chb ();
         assign chb.enable = drive;
         assign chb.open_det = open_b[g];
         assign chb.short_det = short_b[g];
         assign chb.tied_det = tied_b[g];
         assign ch_act[g] = chb.active;
         assign ch_open[g] = chb.open_flag;
         pcd_channel u_ch (
            .clk(clk),
            .rst(rst),
            .ch(chb.ch)
         );
      end
   endgenerate
   // ---------------------------------------------
   // outputs
   // ---------------------------------------------
   wire [CUR_W-1:0] lvl_cur = FULL_SCALE - CUR_W'(level);
   always_ff @(posedge clk) begin
      if (rst) begin
         current_code <= '0;
         channel_pins_en <= '0;
         channel_pins_oe <= '0;
         channel_open <= '0;
         enabled <= 1'b0;
         mode_reeval <= 1'b0;
      end else begin
         current_code <= drive ? lvl_cur : '0;
         channel_pins_en <= ch_act;
         channel_pins_oe <= ch_act;
         channel_open <= ch_open;
         enabled <= run;
         mode_reeval <= ov & run;
      end
   end
endmodule
`default_nettype wire

// *** pkg/pcd_ch_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface pcd_ch_if;
   import pcd_pkg::*;
   logic enable;
   logic open_det;
   logic short_det;
   logic tied_det;
   logic active;
   logic open_flag;
   modport top (output enable, output open_det, output short_det,
      output tied_det, input active, input open_flag);
   modport ch (input enable, input open_det, input short_det,
      input tied_det, output active, output open_flag);
endinterface
`default_nettype wire

// *** pkg/pcd_pkg.sv ***
package pcd_pkg;
   // ---------------------------------------------
   // timing
   // ---------------------------------------------
   localparam int CLK_NS = 40;
   localparam int MIN_LOW_NS = 200;
   localparam int MAX_LOW_NS = 100000;
   localparam int SHDN_LOW_MS = 30;
   localparam int MIN_LOW_CYC = (MIN_LOW_NS + CLK_NS - 1) / CLK_NS;
   localparam int MAX_LOW_CYC = MAX_LOW_NS / CLK_NS;
   localparam int SHDN_LOW_CYC = SHDN_LOW_MS * 1000000 / CLK_NS;
   localparam int CNT_W = 20;
   // ---------------------------------------------
   // levels and channels
   // ---------------------------------------------
   localparam int NCH = 6;
   localparam int LVL_W = 5;
   localparam int CUR_W = 6;
   localparam logic [CUR_W-1:0] FULL_SCALE = 6'h20;
   localparam logic [LVL_W-1:0] LVL_RESET = 5'h00;
   localparam logic [LVL_W-1:0] LVL_STEP = 5'h01;
   typedef enum logic [1:0] {
      PCD_SHDN = 2'b00,
      PCD_RUN = 2'b01,
      PCD_LOW = 2'b10
   } pcd_state_e;
endpackage

// *** verif/pcd_host.sv ***
`timescale 1ns/1ps
`default_nettype none
module pcd_host (
   input wire logic clk,
   output logic dim,
   output logic duty
);
   initial begin
      dim = 1'b0;
      duty = 1'b1;
   end
   // low spell of n cycles; 5..2500 makes a step
   task automatic low(input int n);
      @(posedge clk) dim <= 1'b0;
      repeat (n) @(posedge clk);
      dim <= 1'b1;
   endtask
   task automatic drop;
      @(posedge clk) dim <= 1'b0;
   endtask
   task automatic set_duty(input logic v);
      @(posedge clk) duty <= v;
   endtask
endmodule
`default_nettype wire

// *** verif/pcd_top_chk.sv ***
`timescale 1ns/1ps
`default_nettype none
module pcd_top_chk
   import pcd_pkg::*;
#(
   parameter int SHDN_CYC = SHDN_LOW_CYC
)
(
   input wire logic clk,
   input wire logic rst,
   input wire logic dimming_pulse_input,
   input wire logic duty_input,
   input wire logic pump_overvoltage,
   input wire logic [NCH-1:0] short_det,
   input wire logic [NCH-1:0] tied_det,
   input wire logic [CUR_W-1:0] current_code,
   input wire logic [NCH-1:0] channel_pins_en,
   input wire logic [NCH-1:0] channel_pins_oe,
   input wire logic enabled,
   input wire logic mode_reeval
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // ---------------------------------------------
   // low spell length, saturating
   // ---------------------------------------------
   int lowcnt;
   always_ff @(posedge clk) begin
      if (rst || dimming_pulse_input) lowcnt <= 0;
      else if (lowcnt < SHDN_CYC + 8) lowcnt <= lowcnt + 1;
   end
   sequence s_glitch;
      dimming_pulse_input ##1 !dimming_pulse_input [*3]
         ##1 dimming_pulse_input;
   endsequence
   property p_off;
      !enabled [*2] |-> channel_pins_oe == 6'h00 && current_code == 6'h00;
   endproperty
   property p_duty;
      !duty_input [*4] |=> current_code == 6'h00;
   endproperty
   property p_step;
      current_code != 6'h00 && $past(current_code) != 6'h00
         && $changed(current_code)
         |-> current_code == $past(current_code) - 6'h01
         || ($past(current_code) == 6'h01 && current_code == FULL_SCALE);
   endproperty
   property p_glitch;
      s_glitch |=> $stable(current_code) [*6];
   endproperty
   property p_wake;
      !enabled && duty_input && $rose(dimming_pulse_input)
         |-> ##[2:6] current_code == FULL_SCALE;
   endproperty
   property p_shdn;
      lowcnt == SHDN_CYC + 8 |-> !enabled;
   endproperty
   property p_ov;
      (pump_overvoltage && enabled && dimming_pulse_input) [*4] |=> mode_reeval;
   endproperty
   property p_fault;
      $stable(short_det | tied_det) [*8]
         |-> (channel_pins_en & (short_det | tied_det)) == 6'h00;
   endproperty
   a_off: assert property (p_off) else $error("pins on while off");
   a_duty: assert property (p_duty) else $error("current with duty low");
   a_step: assert property (p_step) else $error("bad level step");
   a_glitch: assert property (p_glitch) else $error("glitch stepped");
   a_wake: assert property (p_wake) else $error("no full scale");
   a_shdn: assert property (p_shdn) else $error("no shutdown");
   a_ov: assert property (p_ov) else $error("no re-evaluation");
   a_fault: assert property (p_fault) else $error("faulty pin on");
endmodule
bind pcd_top pcd_top_chk #(.SHDN_CYC(SHDN_CYC)) chk (.*);
`default_nettype wire

// *** verif/pulse_count_dimming_control_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module pulse_count_dimming_control_tb;
   import pcd_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic ov;
   logic [NCH-1:0] opn;
   logic [NCH-1:0] sht;
   logic [NCH-1:0] tie;
   logic dim, duty, on, reeval;
   logic [5:0] code, en, oe, cop;
   int fail_count = 0;
   int compares = 0;
   pcd_host host (.clk(clk), .dim(dim), .duty(duty));
   pcd_top #(.SHDN_CYC(3000)) uut (.clk(clk), .rst(rst),
      .dimming_pulse_input(dim), .duty_input(duty), .pump_overvoltage(ov),
      .open_det(opn), .short_det(sht), .tied_det(tie), .current_code(code),
      .channel_pins_en(en), .channel_pins_oe(oe), .channel_open(cop),
      .enabled(on), .mode_reeval(reeval));
   initial forever #20 clk = ~clk;
   task automatic chk(input logic [5:0] got, input logic [5:0] exp);
      compares++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value at %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic settle;
      repeat (10) @(posedge clk);
   endtask
   task automatic test_done;
      $display("fail_count %0d compares %0d", fail_count, compares);
      if (fail_count == 0 && compares > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic t_steps;
      for (int i = 1; i <= 32; i++) begin
         host.low(i == 1 ? 2500 : 5);
         settle();
         chk(code, FULL_SCALE - 6'(i % 32));
      end
      host.low(3);
      host.low(2600);
      settle();
      chk(code, FULL_SCALE);
   endtask
   task automatic t_duty;
      host.set_duty(1'b0);
      settle();
      chk(code, 6'h00);
      host.set_duty(1'b1);
      settle();
      chk(code, 6'h1f);
   endtask
   task automatic t_fault;
      @(posedge clk) {sht, tie, opn} <= {6'h02, 6'h04, 6'h08};
      settle();
      chk(oe, 6'h39);
      chk(cop, 6'h08);
      @(posedge clk) {sht, tie, opn} <= '0;
      settle();
      chk(en, 6'h3f);
      chk(cop, 6'h00);
   endtask
   task automatic t_ov;
      @(posedge clk) ov <= 1'b1;
      settle();
      chk({5'h00, reeval}, 6'h01);
      @(posedge clk) ov <= 1'b0;
      settle();
      chk(code, FULL_SCALE);
   endtask
   task automatic t_shdn;
      host.low(5);
      host.drop();
      repeat (3030) @(posedge clk);
      chk({on, oe[0], code[4:1]}, 6'h00);
      host.low(1);
      settle();
      chk(code, FULL_SCALE);
      chk({5'h00, on}, 6'h01);
   endtask
   initial begin
      {ov, opn, sht, tie} <= '0;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      settle();
      chk(oe, 6'h00);
      host.low(1);
      settle();
      chk(code, FULL_SCALE);
      t_steps();
      host.low(5);
      t_duty();
      t_fault();
      t_ov();
      t_shdn();
      test_done();
   end
   // watchdog well past the ~9000 cycles the tests take
   initial begin
      repeat (30000) @(posedge clk);
      fail_count++;
      test_done();
   end
endmodule
`default_nettype wire
